// ===== hdl/front_panel_indicator.v
/*
 * front panel status indicator: four two-colour lamps, a view selector,
 * special-state overrides, switch-driven recovery and a wishbone slave.
 * assumes status, speed and activity inputs are on clk_i; the two recovery
 * switches are pins and are synchronised here.
 */
`include "front_panel_consts.vh"
`default_nettype none

// Functional notes
// - four lamps, three selectable views
// - lamp one: error red, good green
// - lamps two-four show copper, optical links
// - signal views: lamp n shows port n
// - input present on receive, missing 20s
// - output present on write, missing 20s
// - special states override selected view
// - error, bootloader, os boot, halt patterns
// - boot failure pattern; locate blinks yellow
// - erase switch: erase, then lamp four yellow
// - fallback switch: revert, then lamp four yellow
// - both switches: full as-shipped restore
module front_panel_indicator #(
    parameter integer SILENCE_CY   = `SILENCE_CYC,
    parameter integer BLINK_CY     = `BLINK_HALF_CYC,
    parameter integer FAIL_YELLOW  = 0
) (
    input  wire        clk_i,
    input  wire        rst_i,
    input  wire        cyc_i,
    input  wire        stb_i,
    input  wire        we_i,
    input  wire [3:0]  adr_i,
    input  wire [3:0]  sel_i,
    input  wire [31:0] dat_i,
    output reg  [31:0] dat_o,
    output reg         ack_o,
    output wire        irq_o,
    input  wire        card_ok_i,
    input  wire        card_error_i,
    input  wire [1:0]  copper_port_a_speed_i,
    input  wire [1:0]  copper_port_b_speed_i,
    input  wire        optical_port_link_i,
    input  wire [3:0]  serial_rx_strobe_i,
    input  wire [3:0]  serial_tx_strobe_i,
    input  wire        boot_media_fail_i,
    input  wire        bootloader_run_i,
    input  wire        os_booting_i,
    input  wire        os_halted_i,
    input  wire        cfg_recovery_sw_i,
    input  wire        img_recovery_sw_i,
    output reg         erase_settings_o,
    output reg         restore_image_o,
    input  wire        erase_done_i,
    input  wire        restore_done_i,
    output reg  [1:0]  lamp_one_o,
    output reg  [1:0]  lamp_two_o,
    output reg  [1:0]  lamp_three_o,
    output reg  [1:0]  lamp_four_o
);

    localparam [1:0] ST_START = 2'h0;
    localparam [1:0] ST_RUN   = 2'h1;
    localparam [1:0] ST_RECOV = 2'h2;
    localparam [1:0] ST_DONE  = 2'h3;

    localparam [31:0] BLINK_LAST = BLINK_CY - 1;

    reg  [2:0]  ctrl_r;
    reg  [3:0]  irq_stat_r;
    reg  [3:0]  irq_stat_nxt;
    reg  [3:0]  irq_mask_r;
    reg  [1:0]  sw_meta_r;
    reg  [1:0]  sw_sync_r;
    reg  [1:0]  state_r;
    reg         erase_ok_r;
    reg         restore_ok_r;
    reg  [31:0] blink_cnt_r;
    reg         blink_r;
    reg  [3:0]  rx_prev_r;
    reg  [3:0]  tx_prev_r;
    reg         err_prev_r;
    reg  [7:0]  lamps_nxt;
    reg  [31:0] rd_data;
    wire [3:0]  rx_present;
    wire [3:0]  tx_present;
    wire [1:0]  view;
    wire        bus_req;
    wire        wr_lo;
    wire        recov_done_evt;

    assign view    = ctrl_r[`CTRL_VIEW_MSB:`CTRL_VIEW_LSB];
    assign bus_req = cyc_i & stb_i & ~ack_o;
    assign wr_lo   = bus_req & we_i & sel_i[0];

    // ****************************************************************
    // per-port signal-present timers
    // ****************************************************************
    genvar p;
    generate
        for (p = 0; p < 4; p = p + 1) begin : g_port
            activity_timer #(
                .CW         (28),
                .SILENCE_CY (SILENCE_CY)
            ) u_rx (
                .clk_i     (clk_i),
                .rst_i     (rst_i),
                .strobe_i  (serial_rx_strobe_i[p]),
                .present_o (rx_present[p])
            );
            activity_timer #(
                .CW         (28),
                .SILENCE_CY (SILENCE_CY)
            ) u_tx (
                .clk_i     (clk_i),
                .rst_i     (rst_i),
                .strobe_i  (serial_tx_strobe_i[p]),
                .present_o (tx_present[p])
            );
        end
    endgenerate

    // ****************************************************************
    // recovery switch synchroniser and insertion sequence
    // ****************************************************************
    // switches are only honoured at insertion; a later flip waits for the
    // next reset, so a card is never wiped while it is running
    // not reset: it fills while reset is held, so START sees the switches
    always @(posedge clk_i) begin
        sw_meta_r <= {img_recovery_sw_i, cfg_recovery_sw_i};
        sw_sync_r <= sw_meta_r;
    end

    assign recov_done_evt = (state_r == ST_RECOV) &&
                            (erase_ok_r | ~erase_settings_o) &&
                            (restore_ok_r | ~restore_image_o);

    always @(posedge clk_i) begin
        if (rst_i) begin
            state_r          <= ST_START;
            erase_settings_o <= 1'b0;
            restore_image_o  <= 1'b0;
            erase_ok_r       <= 1'b0;
            restore_ok_r     <= 1'b0;
        end else begin
            case (state_r)
                ST_START: begin
                    // sampled after the synchroniser has filled
                    erase_settings_o <= sw_sync_r[0];
                    restore_image_o  <= sw_sync_r[1];
                    state_r          <= (|sw_sync_r) ? ST_RECOV : ST_RUN;
                end
                ST_RECOV: begin
                    if (erase_done_i)
                        erase_ok_r <= 1'b1;
                    if (restore_done_i)
                        restore_ok_r <= 1'b1;
                    if (recov_done_evt) begin
                        erase_settings_o <= 1'b0;
                        restore_image_o  <= 1'b0;
                        state_r          <= ST_DONE;
                    end
                end
                ST_RUN:  state_r <= ST_RUN;
                ST_DONE: state_r <= ST_DONE;
                default: state_r <= ST_START;
            endcase
        end
    end

    // ****************************************************************
    // locate blink divider
    // ****************************************************************
    always @(posedge clk_i) begin
        if (rst_i) begin
            blink_cnt_r <= 32'h0;
            blink_r     <= 1'b0;
        end else if (blink_cnt_r == BLINK_LAST) begin
            blink_cnt_r <= 32'h0;
            blink_r     <= ~blink_r;
        end else begin
            blink_cnt_r <= blink_cnt_r + 32'h1;
        end
    end

    // ****************************************************************
    // lamp selection
    // ****************************************************************
    function [1:0] copper_colour;
        input [1:0] speed;
        begin
            case (speed)
                `SPEED_10M:  copper_colour = `LAMP_RED;
                `SPEED_100M: copper_colour = `LAMP_YELLOW;
                `SPEED_1G:   copper_colour = `LAMP_GREEN;
                default:     copper_colour = `LAMP_OFF;
            endcase
        end
    endfunction

    function [7:0] present_lamps;
        input [3:0] pres;
        integer i;
        begin
            present_lamps = 8'h00;
            for (i = 0; i < 4; i = i + 1)
                if (pres[i])
                    present_lamps[2*i +: 2] = `LAMP_GREEN;
        end
    endfunction

    // lamps_nxt packs lamp one in bits 1:0 up to lamp four in bits 7:6
    always @* begin
        case (view)
            `VIEW_SER_IN:  lamps_nxt = present_lamps(rx_present);
            `VIEW_SER_OUT: lamps_nxt = present_lamps(tx_present);
            default: begin
                lamps_nxt[1:0] = card_error_i ? `LAMP_RED :
                                 (card_ok_i ? `LAMP_GREEN : `LAMP_OFF);
                lamps_nxt[3:2] = copper_colour(copper_port_a_speed_i);
                lamps_nxt[5:4] = copper_colour(copper_port_b_speed_i);
                lamps_nxt[7:6] = optical_port_link_i ? `LAMP_GREEN : `LAMP_OFF;
            end
        endcase
        // later assignments win: the order below is the override priority
        if (os_halted_i)
            lamps_nxt = {`LAMP_YELLOW, 6'h00};
        if (os_booting_i)
            lamps_nxt = {4'h0, `LAMP_YELLOW, 2'h0};
        if (bootloader_run_i)
            lamps_nxt = {6'h00, `LAMP_YELLOW};
        if (boot_media_fail_i)
            lamps_nxt = (FAIL_YELLOW != 0) ? {4{`LAMP_YELLOW}} : 8'h00;
        if (card_error_i)
            lamps_nxt = {6'h00, `LAMP_RED};
        if (ctrl_r[`CTRL_LOCATE_BIT])
            lamps_nxt = blink_r ? {4{`LAMP_YELLOW}} : 8'h00;
        if (state_r == ST_RECOV)
            lamps_nxt = 8'h00;
        if (state_r == ST_DONE)
            lamps_nxt = {`LAMP_YELLOW, 6'h00};
    end

    always @(posedge clk_i) begin
        if (rst_i) begin
            lamp_one_o   <= `LAMP_OFF;
            lamp_two_o   <= `LAMP_OFF;
            lamp_three_o <= `LAMP_OFF;
            lamp_four_o  <= `LAMP_OFF;
        end else begin
            lamp_one_o   <= lamps_nxt[1:0];
            lamp_two_o   <= lamps_nxt[3:2];
            lamp_three_o <= lamps_nxt[5:4];
            lamp_four_o  <= lamps_nxt[7:6];
        end
    end

    // ****************************************************************
    // event capture and interrupt
    // ****************************************************************
    always @(posedge clk_i) begin
        if (rst_i) begin
            rx_prev_r  <= 4'h0;
            tx_prev_r  <= 4'h0;
            err_prev_r <= 1'b0;
        end else begin
            rx_prev_r  <= rx_present;
            tx_prev_r  <= tx_present;
            err_prev_r <= card_error_i;
        end
    end

    // a new event wins over a write-one-to-clear in the same cycle
    always @* begin
        irq_stat_nxt = irq_stat_r;
        if (wr_lo && adr_i == `REG_IRQ_STAT_ADDR)
            irq_stat_nxt = irq_stat_r & ~dat_i[3:0];
        if (card_error_i & ~err_prev_r)
            irq_stat_nxt[`IRQ_CARD_ERROR] = 1'b1;
        if (recov_done_evt)
            irq_stat_nxt[`IRQ_RECOVERY_DONE] = 1'b1;
        if (rx_present != rx_prev_r)
            irq_stat_nxt[`IRQ_RX_CHANGE] = 1'b1;
        if (tx_present != tx_prev_r)
            irq_stat_nxt[`IRQ_TX_CHANGE] = 1'b1;
    end

    assign irq_o = |(irq_stat_r & irq_mask_r);

    // ****************************************************************
    // wishbone slave
    // ****************************************************************
    always @* begin
        case (adr_i)
            `REG_CTRL_ADDR:     rd_data = {29'h0, ctrl_r};
            `REG_STATE_ADDR:    rd_data = {14'h0, state_r, lamp_four_o, lamp_three_o,
                                           lamp_two_o, lamp_one_o, tx_present, rx_present};
            `REG_IRQ_STAT_ADDR: rd_data = {28'h0, irq_stat_r};
            `REG_IRQ_MASK_ADDR: rd_data = {28'h0, irq_mask_r};
            default:            rd_data = 32'h0;
        endcase
    end

    always @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_r     <= `CTRL_RESET;
            irq_mask_r <= `IRQ_MASK_RESET;
            irq_stat_r <= 4'h0;
            ack_o      <= 1'b0;
            dat_o      <= 32'h0;
        end else begin
            irq_stat_r <= irq_stat_nxt;
            ack_o      <= bus_req;
            if (bus_req)
                dat_o <= we_i ? 32'h0 : rd_data;
            if (wr_lo && adr_i == `REG_CTRL_ADDR)
                ctrl_r <= dat_i[2:0];
            if (wr_lo && adr_i == `REG_IRQ_MASK_ADDR)
                irq_mask_r <= dat_i[3:0];
        end
    end

endmodule

`default_nettype wire

// ===== hdl/front_panel_consts.vh
/*
 * constants shared by the front panel status indicator: register map,
 * field positions, reset values, lamp colour codes and timing figures.
 * assumes a 10 MHz system clock and a 32-bit classic wishbone register bus.
 */
`ifndef FRONT_PANEL_CONSTS_VH
`define FRONT_PANEL_CONSTS_VH

// ****************************************************************
// register byte offsets
// ****************************************************************
`define REG_CTRL_ADDR        4'h0
`define REG_STATE_ADDR       4'h4
`define REG_IRQ_STAT_ADDR    4'h8
`define REG_IRQ_MASK_ADDR    4'hC

// ****************************************************************
// control register fields and reset values
// ****************************************************************
`define CTRL_VIEW_LSB        0
`define CTRL_VIEW_MSB        1
`define CTRL_LOCATE_BIT      2
`define CTRL_RESET           3'h0
`define IRQ_MASK_RESET       4'h0

// ****************************************************************
// indicator view codes
// ****************************************************************
`define VIEW_NORMAL          2'h0
`define VIEW_SER_IN          2'h1
`define VIEW_SER_OUT         2'h2

// ****************************************************************
// interrupt status bits
// ****************************************************************
`define IRQ_CARD_ERROR       0
`define IRQ_RECOVERY_DONE    1
`define IRQ_RX_CHANGE        2
`define IRQ_TX_CHANGE        3

// ****************************************************************
// lamp colours and copper link speed codes
// ****************************************************************
`define LAMP_OFF             2'h0
`define LAMP_RED             2'h1
`define LAMP_YELLOW          2'h2
`define LAMP_GREEN           2'h3
`define SPEED_NONE           2'h0
`define SPEED_10M            2'h1
`define SPEED_100M           2'h2
`define SPEED_1G             2'h3

// ****************************************************************
// timing
// ****************************************************************
`define CLK_KHZ              10000
`define SILENCE_MS           20000
`define BLINK_HALF_MS        500
`define SILENCE_CYC          (`SILENCE_MS * `CLK_KHZ)
`define BLINK_HALF_CYC       (`BLINK_HALF_MS * `CLK_KHZ)

`endif

// ===== hdl/activity_timer.v
/*
 * one signal-present tracker for a serial port direction.
 * assumes the activity strobe is a single-cycle pulse on the same clock.
 */
`default_nettype none

module activity_timer #(
    parameter integer CW         = 28,
    parameter integer SILENCE_CY = 200000000
) (
    input  wire clk_i,
    input  wire rst_i,
    input  wire strobe_i,
    output wire present_o
);

    localparam [31:0]   LAST32 = SILENCE_CY - 1;
    localparam [CW-1:0] LAST   = LAST32[CW-1:0];

    reg [CW-1:0] count_r;
    reg          present_r;

    // ****************************************************************
    // silence timer
    // ****************************************************************
    always @(posedge clk_i) begin
        if (rst_i) begin
            count_r   <= {CW{1'b0}};
            present_r <= 1'b0;
        end else if (strobe_i) begin
            count_r   <= {CW{1'b0}};
            present_r <= 1'b1;
        end else if (present_r) begin
            if (count_r == LAST) begin
                present_r <= 1'b0;
                count_r   <= {CW{1'b0}};
            end else begin
                count_r   <= count_r + 1'b1;
            end
        end
    end

    assign present_o = present_r;

endmodule

`default_nettype wire

// ===== verification/fp_checker_asserts.sv
/* checker for front_panel_indicator: lamp patterns, presence timing, blink, recovery.
   assumes it is bound to that module and sees only its ports. */
`default_nettype none
`include "front_panel_consts.vh"
module fp_checker #(
    parameter integer SILENCE_CY  = 50,
    parameter integer BLINK_CY    = 4,
    parameter integer FAIL_YELLOW = 0
) (
    input wire logic        clk_i,
    input wire logic        rst_i,
    input wire logic        cyc_i,
    input wire logic        stb_i,
    input wire logic        we_i,
    input wire logic [3:0]  adr_i,
    input wire logic [3:0]  sel_i,
    input wire logic [31:0] dat_i,
    input wire logic        ack_o,
    input wire logic        card_ok_i,
    input wire logic        card_error_i,
    input wire logic [1:0]  copper_port_a_speed_i,
    input wire logic [1:0]  copper_port_b_speed_i,
    input wire logic        optical_port_link_i,
    input wire logic [3:0]  serial_rx_strobe_i,
    input wire logic        boot_media_fail_i,
    input wire logic        bootloader_run_i,
    input wire logic        os_booting_i,
    input wire logic        os_halted_i,
    input wire logic        cfg_recovery_sw_i,
    input wire logic        img_recovery_sw_i,
    input wire logic        erase_settings_o,
    input wire logic        restore_image_o,
    input wire logic [1:0]  lamp_one_o,
    input wire logic [1:0]  lamp_two_o,
    input wire logic [1:0]  lamp_three_o,
    input wire logic [1:0]  lamp_four_o
);
    // ****************
    // mirrors of control state seen on the bus and at reset
    // ****************
    logic [1:0] view_r, up_r;
    logic       loc_r, cfg_r, img_r;
    int         sil_r, loc_cnt_r;
    wire        wr_ctrl = cyc_i && stb_i && !ack_o && we_i && sel_i[0] && adr_i == `REG_CTRL_ADDR;
    // the first edges after reset still show start-up values, so checks wait for up_r
    wire        quiet = !cfg_r && !img_r && up_r == 2'h3;
    wire        calm = quiet && !loc_r;
    wire        nospec = calm && !card_error_i && !boot_media_fail_i && !bootloader_run_i && !os_booting_i
                         && !os_halted_i;
    wire        norm = view_r != `VIEW_SER_IN && view_r != `VIEW_SER_OUT;
    wire        in_view = nospec && view_r == `VIEW_SER_IN;
    wire [7:0]  lamps = {lamp_one_o, lamp_two_o, lamp_three_o, lamp_four_o};
    always @(posedge clk_i) begin
        if (rst_i) begin
            view_r <= `VIEW_NORMAL;
            loc_r <= 1'b0;
            up_r <= 2'h0;
            sil_r <= SILENCE_CY + 8;
            loc_cnt_r <= 0;
            cfg_r <= cfg_recovery_sw_i;
            img_r <= img_recovery_sw_i;
        end else begin
            if (wr_ctrl) begin
                view_r <= dat_i[1:0];
                loc_r <= dat_i[2];
            end
            if (up_r != 2'h3)
                up_r <= up_r + 2'h1;
            if (serial_rx_strobe_i[0])
                sil_r <= 0;
            else if (sil_r < SILENCE_CY + 8)
                sil_r <= sil_r + 1;
            loc_cnt_r <= (quiet && loc_r) ? loc_cnt_r + 32'(loc_cnt_r < 255) : 0;
        end
    end
    // ****************
    // properties
    // ****************
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    sequence s_recovering; (cfg_r || img_r) && up_r == 2'h3; endsequence
    sequence s_done_pattern; lamps == 8'h02; endsequence
    property p_norm_one; nospec && norm |=> lamp_one_o == ($past(card_ok_i) ? `LAMP_GREEN : `LAMP_OFF); endproperty
    a_norm_one: assert property (p_norm_one) else $error("lamp one view");
    property p_links; nospec && norm |=> lamp_two_o == $past(copper_port_a_speed_i) &&
        lamp_three_o == $past(copper_port_b_speed_i) &&
        lamp_four_o == ($past(optical_port_link_i) ? `LAMP_GREEN : `LAMP_OFF); endproperty
    a_links: assert property (p_links) else $error("link lamps");
    property p_err; calm && card_error_i |=> lamps == 8'h40; endproperty
    a_err: assert property (p_err) else $error("error pattern");
    property p_fail; calm && !card_error_i && boot_media_fail_i |=> lamps == (FAIL_YELLOW ? 8'hAA : 8'h00); endproperty
    a_fail: assert property (p_fail) else $error("boot fail pattern");
    property p_loader; calm && !card_error_i && !boot_media_fail_i && bootloader_run_i |=> lamps == 8'h80; endproperty
    a_loader: assert property (p_loader) else $error("loader pattern");
    property p_loc; quiet && loc_r |=> lamps == 8'hAA || lamps == 8'h00; endproperty
    a_loc: assert property (p_loc) else $error("locate pattern");
    property p_blink; loc_cnt_r > BLINK_CY + 2 |-> lamp_one_o != $past(lamp_one_o, BLINK_CY); endproperty
    a_blink: assert property (p_blink) else $error("blink period");
    property p_present; in_view && sil_r < SILENCE_CY - 2 |=> lamp_one_o == `LAMP_GREEN; endproperty
    a_present: assert property (p_present) else $error("port one present");
    property p_missing; in_view && sil_r > SILENCE_CY + 2 |=> lamp_one_o == `LAMP_OFF; endproperty
    a_missing: assert property (p_missing) else $error("port one missing");
    property p_rec_lamps; s_recovering |-> lamps == 8'h00 || lamps == 8'h02; endproperty
    a_rec_lamps: assert property (p_rec_lamps) else $error("recovery lamps");
    property p_rec_hold; s_recovering ##0 s_done_pattern |=> s_done_pattern; endproperty
    a_rec_hold: assert property (p_rec_hold) else $error("done pattern lost");
    property p_req; (erase_settings_o |-> cfg_r) and (restore_image_o |-> img_r); endproperty
    a_req: assert property (p_req) else $error("recovery request");
endmodule
bind front_panel_indicator fp_checker #(.SILENCE_CY(SILENCE_CY), .BLINK_CY(BLINK_CY), .FAIL_YELLOW(FAIL_YELLOW))
    i_chk (.*);
`default_nettype wire

// ===== verification/recovery_agent.sv
/* settings and image stores answering recovery requests, erase promptly, image slowly.
   assumes the requests are levels on the same clock. */
`default_nettype none
module recovery_agent #(
    parameter integer ERASE_CY = 6,
    parameter integer IMAGE_CY = 40
) (
    input  wire logic clk_i,
    input  wire logic rst_i,
    input  wire logic erase_req_i,
    input  wire logic image_req_i,
    output wire logic erase_done_o,
    output wire logic image_done_o
);
    timeunit 1ns;
    timeprecision 1ns;
    // ****************
    // one completion pulse per request; a held request is not answered twice
    // ****************
    int ecnt = 0;
    int icnt = 0;
    always @(posedge clk_i) begin
        ecnt <= (rst_i || !erase_req_i) ? 0 : ecnt + 32'(ecnt <= ERASE_CY);
        icnt <= (rst_i || !image_req_i) ? 0 : icnt + 32'(icnt <= IMAGE_CY);
    end
    assign erase_done_o = erase_req_i && ecnt == ERASE_CY;
    assign image_done_o = image_req_i && icnt == IMAGE_CY;
endmodule
`default_nettype wire

// ===== verification/front_panel_status_indicator_tb.sv
/* self-checking bench for front_panel_indicator: lamp table, views, bus, irq, locate, recovery.
   assumes recovery_agent answers the recovery requests. */
`default_nettype none
`include "front_panel_consts.vh"
`define CHK(nm, ex, got) begin n_compared++; if ((got) !== (ex)) begin bad_count++; \
    $display("[FAIL] %s expected %h seen %h", nm, ex, got); end end
module front_panel_status_indicator_tb;
    timeunit 1ns;
    timeprecision 1ns;
    // ****************
    // stimulus, table and instances
    // ****************
    logic        clk_i = 1'b0, rst_i = 1'b1, cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0, ok_i = 1'b0;
    logic        err_i = 1'b0, opt_i = 1'b0, bf_i = 1'b0, bl_i = 1'b0, osb_i = 1'b0, osh_i = 1'b0;
    logic        cfg_i = 1'b0, isw_i = 1'b0, ack_o, irq_o, ers_o, rim_o, ers_done, img_done;
    logic [1:0]  spa_i = 2'h0, spb_i = 2'h0, seen_r;
    logic [3:0]  adr_i = 4'h0, sel_i = 4'h0, rx_i = 4'h0, tx_i = 4'h0;
    logic [31:0] dat_i = 32'h0, dat_o, rd;
    logic [7:0]  lamps;
    int          bad_count = 0, n_compared = 0, k, n;
    // {error, boot fail, loader, os boot, os halt} {ok, speed a, speed b, optical} expected lamps
    logic [18:0] rows [12] = '{{5'h00, 6'h20, 8'hC0}, {5'h00, 6'h2D, 8'hDB}, {5'h00, 6'h3A, 8'hF4},
        {5'h00, 6'h17, 8'h2F}, {5'h10, 6'h3F, 8'h40}, {5'h08, 6'h3F, 8'h00}, {5'h04, 6'h3F, 8'h80},
        {5'h02, 6'h3F, 8'h20}, {5'h01, 6'h3F, 8'h02}, {5'h14, 6'h3F, 8'h40}, {5'h05, 6'h3F, 8'h80},
        {5'h03, 6'h3F, 8'h20}};
    initial forever #50 clk_i = ~clk_i;
    always @(posedge clk_i) seen_r <= rst_i ? 2'h0 : seen_r | {rim_o, ers_o};
    front_panel_indicator #(.SILENCE_CY(50), .BLINK_CY(4), .FAIL_YELLOW(0)) i_dut (
        .clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i, .dat_o, .ack_o, .irq_o, .card_ok_i(ok_i),
        .card_error_i(err_i), .copper_port_a_speed_i(spa_i), .copper_port_b_speed_i(spb_i),
        .optical_port_link_i(opt_i), .serial_rx_strobe_i(rx_i), .serial_tx_strobe_i(tx_i),
        .boot_media_fail_i(bf_i), .bootloader_run_i(bl_i), .os_booting_i(osb_i), .os_halted_i(osh_i),
        .cfg_recovery_sw_i(cfg_i), .img_recovery_sw_i(isw_i), .erase_settings_o(ers_o),
        .restore_image_o(rim_o), .erase_done_i(ers_done), .restore_done_i(img_done),
        .lamp_one_o(lamps[7:6]), .lamp_two_o(lamps[5:4]), .lamp_three_o(lamps[3:2]), .lamp_four_o(lamps[1:0]));
    recovery_agent i_agent (.clk_i, .rst_i, .erase_req_i(ers_o), .image_req_i(rim_o),
        .erase_done_o(ers_done), .image_done_o(img_done));
    // ****************
    // tasks
    // ****************
    task automatic finish_test();
        $display("compared %0d mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    // outputs are looked at mid-cycle so they are settled
    task automatic look(input int c);
        repeat (c) @(posedge clk_i);
        @(negedge clk_i);
    endtask
    task automatic do_reset();
        @(posedge clk_i);
        rst_i <= 1'b1;
        repeat (20) @(posedge clk_i);
        rst_i <= 1'b0;
    endtask
    task automatic pulse(input logic [3:0] r, t);
        @(posedge clk_i);
        {rx_i, tx_i} <= {r, t};
        @(posedge clk_i);
        {rx_i, tx_i} <= 8'h0;
    endtask
    task automatic wb(input logic w, input logic [3:0] a, s, input logic [31:0] d);
        int t = 0;
        @(posedge clk_i);
        {cyc_i, stb_i, we_i, adr_i, sel_i, dat_i} <= {1'b1, 1'b1, w, a, s, d};
        do begin
            @(posedge clk_i);
            t++;
        end while (ack_o !== 1'b1 && t < 40);
        rd = dat_o;
        {cyc_i, stb_i, we_i} <= 3'h0;
        if (t >= 40) begin
            bad_count++;
            finish_test();
        end
    endtask
    // ****************
    // main sequence
    // ****************
    initial begin
        do_reset();
        look(4);
        wb(1'b0, `REG_STATE_ADDR, 4'hF, 32'h0);
        `CHK("present flags", 8'h00, rd[7:0])
        for (k = 0; k < 12; k++) begin
            @(posedge clk_i);
            {err_i, bf_i, bl_i, osb_i, osh_i, ok_i, spa_i, spb_i, opt_i} <= rows[k][18:8];
            look(2);
            `CHK("lamps", rows[k][7:0], lamps)
        end
        @(posedge clk_i);
        {err_i, bf_i, bl_i, osb_i, osh_i} <= 5'h00;
        wb(1'b1, `REG_CTRL_ADDR, 4'hE, 32'h1);
        wb(1'b0, `REG_CTRL_ADDR, 4'hF, 32'h0);
        `CHK("ctrl byte lane", 32'h0, rd)
        wb(1'b0, 4'h2, 4'hF, 32'h0);
        `CHK("unmapped read", 32'h0, rd)
        wb(1'b1, `REG_CTRL_ADDR, 4'hF, {30'h0, `VIEW_SER_IN});
        pulse(4'h5, 4'h0);
        look(2);
        `CHK("rx present", 8'hCC, lamps)
        look(30);
        pulse(4'h1, 4'h0);
        look(30);
        `CHK("rx restart", 8'hC0, lamps)
        look(30);
        `CHK("rx missing", 8'h00, lamps)
        wb(1'b1, `REG_CTRL_ADDR, 4'hF, {30'h0, `VIEW_SER_OUT});
        pulse(4'hF, 4'h8);
        look(2);
        `CHK("tx present", 8'h03, lamps)
        look(60);
        `CHK("tx missing", 8'h00, lamps)
        wb(1'b1, `REG_IRQ_STAT_ADDR, 4'hF, 32'hF);
        @(posedge clk_i);
        err_i <= 1'b1;
        look(3);
        `CHK("irq masked", 1'b0, irq_o)
        wb(1'b0, `REG_IRQ_STAT_ADDR, 4'hF, 32'h0);
        `CHK("error event", 4'h1, rd[3:0])
        wb(1'b1, `REG_IRQ_MASK_ADDR, 4'hF, 32'h1);
        look(1);
        `CHK("irq raised", 1'b1, irq_o)
        wb(1'b1, `REG_IRQ_STAT_ADDR, 4'hF, 32'h1);
        look(1);
        `CHK("irq cleared", 1'b0, irq_o)
        wb(1'b1, `REG_CTRL_ADDR, 4'hF, 32'h4);
        look(4);
        n = 0;
        repeat (16) begin
            look(1);
            n += int'(lamps == 8'hAA);
            `CHK("blink pattern", 1'b1, lamps == 8'hAA || lamps == 8'h00)
        end
        `CHK("blink yellow cycles", 8, n)
        for (k = 1; k < 4; k++) begin
            @(posedge clk_i);
            {err_i, cfg_i, isw_i} <= {1'b0, k[0], k[1]};
            do_reset();
            n = 0;
            do begin
                look(1);
                n++;
            end while (lamps !== 8'h02 && n < 300);
            look(5);
            `CHK("recovery done", 8'h02, lamps)
            `CHK("requests", k[1:0], seen_r)
        end
        @(posedge clk_i);
        {cfg_i, isw_i} <= 2'h0;
        do_reset();
        look(4);
        `CHK("reinserted", 8'hFF, lamps)
        finish_test();
    end
endmodule
`default_nettype wire
